// ===== ccpo_core.sv
`timescale 1ns/1ns
module ccpo_core #(
    parameter int W = ccpo_pkg::CNT_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] on_width,
    input  wire logic [W-1:0] cycle,
    output logic              pwm_out
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_out;

    if (W < ccpo_pkg::CNT_W)
    begin : g_bad_w
        $error("ccpo_core: counter too narrow for the longest cycle");
    end

    // Off part of the period comes first, so a fresh start is low
    always_comb
    begin
        next_cnt = cnt;
        next_out = pwm_out;
        if (!run)
        begin
            next_cnt = '0;
            next_out = 1'b0;
        end
        else if (tick)
        begin
            next_cnt = (cnt >= cycle - W'(1)) ? '0 : cnt + W'(1);
            next_out = (on_width != '0) && (cnt >= cycle - on_width);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt     <= '0;
            pwm_out <= 1'b0;
        end
        else
        begin
            cnt     <= next_cnt;
            pwm_out <= next_out;
        end
    end

endmodule : ccpo_core

// ===== ccpo_load.sv
`timescale 1ns/1ns
module ccpo_load (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pwm_in,
    output logic      [31:0] high_len,
    output logic      [31:0] period,
    output logic      [31:0] rises
);
    // A plain load only sinks the pin; it measures the last high run and rise-to-rise time
    logic        last;
    logic [31:0] run_hi;
    logic [31:0] since_rise;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last       <= 1'b0;
            run_hi     <= 32'h0000_0000;
            since_rise <= 32'h0000_0000;
            high_len   <= 32'h0000_0000;
            period     <= 32'h0000_0000;
            rises      <= 32'h0000_0000;
        end
        else
        begin
            last       <= pwm_in;
            since_rise <= since_rise + 32'h0000_0001;
            if (pwm_in)
                run_hi <= run_hi + 32'h0000_0001;
            if (pwm_in && !last)
            begin
                rises      <= rises + 32'h0000_0001;
                period     <= since_rise;
                since_rise <= 32'h0000_0001;
                run_hi     <= 32'h0000_0001;
            end
            if (!pwm_in && last)
                high_len <= run_hi;
        end
    end
endmodule : ccpo_load

// ===== ccpo_pkg.sv
package ccpo_pkg;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  ON_WIDTH_OFS  = 8'h04;
    localparam logic [7:0]  CYCLE_OFS     = 8'h08;
    localparam logic [7:0]  ARG_LOC_OFS   = 8'h0C;
    localparam logic [7:0]  AREA_END_OFS  = 8'h10;
    localparam logic [7:0]  EXEC_OFS      = 8'h14;
    localparam logic [7:0]  ERR_FLAG_OFS  = 8'h18;
    localparam logic [7:0]  ERR_CODE_OFS  = 8'h1C;
    localparam logic [7:0]  STATUS_OFS    = 8'h20;

    // Control register fields
    localparam int CTRL_HSC_EN_BIT   = 0;
    localparam int CTRL_MODE_LSB     = 1;
    localparam int CTRL_MODE_W       = 3;
    localparam int CTRL_OUT2_OFF_BIT = 4;
    localparam int CTRL_MATCH_EN_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Operation modes of the channel
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_FREQ     = 3'h1;
    localparam logic [2:0] MODE_ROTATION = 3'h2;
    localparam logic [2:0] MODE_PULSE    = 3'h3;
    localparam logic [2:0] MODE_PWM      = 3'h4;

    // Operation error codes
    localparam logic [15:0] ERR_NONE      = 16'h0000;
    localparam logic [15:0] ERR_RANGE     = 16'h1004;
    localparam logic [15:0] ERR_LOCATION  = 16'h1005;
    localparam logic [15:0] ERR_MODE      = 16'h1014;

    // Argument limits in 0.1 us units
    localparam logic [31:0] ON_MIN    = 32'h0000_000A;
    localparam logic [31:0] CYCLE_MIN = 32'h0000_0032;
    localparam logic [31:0] ARG_MAX   = 32'h0098_9680;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 100;
    localparam int TICK_DIV      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 24;

endpackage : ccpo_pkg

// ===== ccpo_tick.sv
`timescale 1ns/1ns
module ccpo_tick #(
    parameter int DIV = ccpo_pkg::TICK_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    localparam int CW = $clog2(DIV + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    if (DIV < 1)
    begin : g_bad_div
        $error("ccpo_tick: DIV must be at least 1");
    end

    always_comb
    begin
        if (cnt == CW'(DIV - 1))
        begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
        else
        begin
            next_cnt  = cnt + CW'(1);
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt  <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule : ccpo_tick

// ===== ccpo_top.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
module ccpo_top #(
    parameter int TICK_DIV = ccpo_pkg::TICK_DIV,
    parameter int CNT_W    = ccpo_pkg::CNT_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             match_out1,
    output logic             match_out2,
    output logic             operation_error_flag
);
    logic [5:0]       ctrl;
    logic [31:0]      on_width;
    logic [31:0]      cycle;
    logic [31:0]      arg_loc;
    logic [15:0]      area_end;
    logic             exec_cond;
    logic [15:0]      operation_error_code;
    logic             running;
    logic [CNT_W-1:0] run_on;
    logic [CNT_W-1:0] run_cycle;
    logic             tick;
    logic             pwm_out;

    logic [5:0]       next_ctrl;
    logic [31:0]      next_on_width;
    logic [31:0]      next_cycle;
    logic [31:0]      next_arg_loc;
    logic [15:0]      next_area_end;
    logic             next_exec_cond;
    logic             next_flag;
    logic [15:0]      next_code;
    logic             next_running;
    logic [CNT_W-1:0] next_run_on;
    logic [CNT_W-1:0] next_run_cycle;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic             next_out2;

    logic             setup;
    logic             wr;
    logic             eval;
    logic             hsc_en;
    logic [2:0]       mode;
    logic             loc_bad;
    logic             range_bad;
    logic [15:0]      eval_code;
    logic             mapped;

    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite;
    assign eval   = wr && (paddr == ccpo_pkg::EXEC_OFS);
    assign hsc_en = ctrl[ccpo_pkg::CTRL_HSC_EN_BIT];
    assign mode   = ctrl[ccpo_pkg::CTRL_MODE_LSB +: ccpo_pkg::CTRL_MODE_W];

    // Each argument occupies two words: both must lie inside the area
    assign loc_bad = ({1'b0, arg_loc[15:0]} + 17'h0_0001 >= {1'b0, area_end})
                  || ({1'b0, arg_loc[31:16]} + 17'h0_0001 >= {1'b0, area_end});

    assign range_bad = ((on_width != 32'h0000_0000) && (on_width < ccpo_pkg::ON_MIN))
                    || (on_width > ccpo_pkg::ARG_MAX)
                    || (cycle < ccpo_pkg::CYCLE_MIN)
                    || (cycle > ccpo_pkg::ARG_MAX);

    // Mode problems mask argument problems, as arguments mean nothing then
    always_comb
    begin
        if (!hsc_en || mode != ccpo_pkg::MODE_PWM)
            eval_code = ccpo_pkg::ERR_MODE;
        else if (loc_bad)
            eval_code = ccpo_pkg::ERR_LOCATION;
        else if (range_bad || on_width > cycle)
            eval_code = ccpo_pkg::ERR_RANGE;
        else
            eval_code = ccpo_pkg::ERR_NONE;
    end

    always_comb
    begin
        unique case (paddr)
            ccpo_pkg::CTRL_OFS,
            ccpo_pkg::ON_WIDTH_OFS,
            ccpo_pkg::CYCLE_OFS,
            ccpo_pkg::ARG_LOC_OFS,
            ccpo_pkg::AREA_END_OFS,
            ccpo_pkg::EXEC_OFS,
            ccpo_pkg::ERR_FLAG_OFS,
            ccpo_pkg::ERR_CODE_OFS,
            ccpo_pkg::STATUS_OFS: mapped = 1'b1;
            default:              mapped = 1'b0;
        endcase
    end

    // Bus answer: zero wait states, data captured in the setup cycle
    always_comb
    begin
        next_pready  = setup;
        next_pslverr = setup && !mapped;
        next_prdata  = 32'h0000_0000;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                ccpo_pkg::CTRL_OFS:     next_prdata = {26'h000_0000, ctrl};
                ccpo_pkg::ON_WIDTH_OFS: next_prdata = on_width;
                ccpo_pkg::CYCLE_OFS:    next_prdata = cycle;
                ccpo_pkg::ARG_LOC_OFS:  next_prdata = arg_loc;
                ccpo_pkg::AREA_END_OFS: next_prdata = {16'h0000, area_end};
                ccpo_pkg::EXEC_OFS:     next_prdata = {31'h0000_0000, exec_cond};
                ccpo_pkg::ERR_FLAG_OFS:
                    next_prdata = {31'h0000_0000, operation_error_flag};
                ccpo_pkg::ERR_CODE_OFS:
                    next_prdata = {16'h0000, operation_error_code};
                ccpo_pkg::STATUS_OFS:
                    next_prdata = {29'h0000_0000, match_out2, match_out1, running};
                default:                next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Software-written configuration
    always_comb
    begin
        next_ctrl      = ctrl;
        next_on_width  = on_width;
        next_cycle     = cycle;
        next_arg_loc   = arg_loc;
        next_area_end  = area_end;
        next_exec_cond = exec_cond;
        if (wr)
        begin
            unique case (paddr)
                ccpo_pkg::CTRL_OFS:     next_ctrl      = pwdata[5:0];
                ccpo_pkg::ON_WIDTH_OFS: next_on_width  = pwdata;
                ccpo_pkg::CYCLE_OFS:    next_cycle     = pwdata;
                ccpo_pkg::ARG_LOC_OFS:  next_arg_loc   = pwdata;
                ccpo_pkg::AREA_END_OFS: next_area_end  = pwdata[15:0];
                ccpo_pkg::EXEC_OFS:     next_exec_cond = pwdata[0];
                default:                next_ctrl      = ctrl;
            endcase
        end
    end

    // Every evaluation checks arguments, whatever the condition says
    always_comb
    begin
        next_flag = operation_error_flag;
        next_code = operation_error_code;
        if (wr && paddr == ccpo_pkg::ERR_FLAG_OFS && pwdata[0])
            next_flag = 1'b0;
        if (eval && eval_code != ccpo_pkg::ERR_NONE)
        begin
            next_flag = 1'b1;
            next_code = eval_code;
        end
    end

    // Generation follows the condition given with each error-free evaluation; an evaluation with an error stops it
    always_comb
    begin
        next_running   = running;
        next_run_on    = run_on;
        next_run_cycle = run_cycle;
        if (eval)
        begin
            next_running = pwdata[0] && eval_code == ccpo_pkg::ERR_NONE;
            if (pwdata[0] && eval_code == ccpo_pkg::ERR_NONE)
            begin
                next_run_on    = on_width[CNT_W-1:0];
                next_run_cycle = cycle[CNT_W-1:0];
            end
        end
    end

    // Second output is on unless software turns it off; the command overrides
    assign next_out2 = !ctrl[ccpo_pkg::CTRL_OUT2_OFF_BIT]
                    || ctrl[ccpo_pkg::CTRL_MATCH_EN_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl                 <= ccpo_pkg::CTRL_RESET;
            on_width             <= 32'h0000_0000;
            cycle                <= 32'h0000_0000;
            arg_loc              <= 32'h0000_0000;
            area_end             <= 16'h0000;
            exec_cond            <= 1'b0;
            operation_error_flag <= 1'b0;
            operation_error_code <= ccpo_pkg::ERR_NONE;
            running              <= 1'b0;
            run_on               <= '0;
            run_cycle            <= '0;
            prdata               <= 32'h0000_0000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            match_out2           <= 1'b1;
        end
        else
        begin
            ctrl                 <= next_ctrl;
            on_width             <= next_on_width;
            cycle                <= next_cycle;
            arg_loc              <= next_arg_loc;
            area_end             <= next_area_end;
            exec_cond            <= next_exec_cond;
            operation_error_flag <= next_flag;
            operation_error_code <= next_code;
            running              <= next_running;
            run_on               <= next_run_on;
            run_cycle            <= next_run_cycle;
            prdata               <= next_prdata;
            pready               <= next_pready;
            pslverr              <= next_pslverr;
            match_out2           <= next_out2;
        end
    end

    ccpo_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    ccpo_core #(
        .W (CNT_W)
    ) u_core (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (running),
        .tick     (tick),
        .on_width (run_on),
        .cycle    (run_cycle),
        .pwm_out  (pwm_out)
    );

    assign match_out1 = pwm_out;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_idle_output_off:
        assert property (!running |=> !match_out1)
        else $error("first output high while generation stopped");
    a_start_off:
        assert property ($rose(running) |-> !match_out1
                         ##1 (!match_out1 || run_on == run_cycle))
        else $error("waveform did not start in the off state");
    a_zero_width_off:
        assert property (running && run_on == '0 |=> !match_out1)
        else $error("zero on width drove the output high");
    a_run_on_ok:
        assert property (eval && pwdata[0] && eval_code == ccpo_pkg::ERR_NONE
                         |=> running)
        else $error("valid instruction did not start generation");
    a_mode_code:
        assert property (eval && mode != ccpo_pkg::MODE_PWM
                         |=> operation_error_flag
                             && operation_error_code == ccpo_pkg::ERR_MODE
                             && !running)
        else $error("wrong mode not reported as 4116");
    a_disabled_code:
        assert property (eval && !hsc_en
                         |=> operation_error_code == ccpo_pkg::ERR_MODE)
        else $error("disabled counter not reported as 4116");
    a_location_code:
        assert property (eval && hsc_en && mode == ccpo_pkg::MODE_PWM && loc_bad
                         |=> operation_error_code == ccpo_pkg::ERR_LOCATION)
        else $error("argument location fault not reported as 4101");
    a_order_code:
        assert property (eval && eval_code != ccpo_pkg::ERR_MODE && !loc_bad
                         && on_width > cycle
                         |=> operation_error_code == ccpo_pkg::ERR_RANGE)
        else $error("on width above cycle not reported as 4100");
    a_range_code:
        assert property (eval && eval_code != ccpo_pkg::ERR_MODE && !loc_bad
                         && range_bad
                         |=> operation_error_code == ccpo_pkg::ERR_RANGE)
        else $error("argument out of range not reported as 4100");
    a_flag_idle_eval:
        assert property (eval && !pwdata[0] && eval_code != ccpo_pkg::ERR_NONE
                         |=> operation_error_flag)
        else $error("error not raised while condition false");
    a_out2_cmd:
        assert property (ctrl[ccpo_pkg::CTRL_MATCH_EN_BIT] |=> match_out2)
        else $error("enable command did not turn second output on");
    a_out2_default:
        assert property (!ctrl[ccpo_pkg::CTRL_OUT2_OFF_BIT] |=> match_out2)
        else $error("second output not on by default");

    c_start:      cover property ($rose(running));
    c_out_rise:   cover property (running ##1 $rose(match_out1));
    c_error:      cover property ($rose(operation_error_flag));
    c_stop:       cover property ($fell(running));

endmodule : ccpo_top

// ===== counter_channel_pwm_output_tb.sv
`timescale 1ns/1ns
module counter_channel_pwm_output_tb;
    localparam int DIV = 1;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] on;
        logic [31:0] cyc;
        logic [31:0] loc;
        logic        cond;
        logic [15:0] code;
    } ccpo_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        match_out1;
    logic        match_out2;
    logic        operation_error_flag;
    logic [31:0] high_len;
    logic [31:0] period;
    logic [31:0] rises;
    logic [31:0] rd;
    logic        er;
    logic [31:0] n;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cyc_cnt = 0;

    // Rows: ctrl, on width, cycle, locations, condition, expected code (0 = none)
    ccpo_row_t rows [16] = '{
        '{32'h0000_0008, 32'h0000_000A, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1014},
        '{32'h0000_0001, 32'h0000_000A, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1014},
        '{32'h0000_0003, 32'h0000_000A, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1014},
        '{32'h0000_0005, 32'h0000_000A, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1014},
        '{32'h0000_0007, 32'h0000_000A, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1014},
        '{32'h0000_0009, 32'h0000_000A, 32'h0000_0032, 32'h0002_000F, 1'b1, 16'h1005},
        '{32'h0000_0009, 32'h0000_000A, 32'h0000_0032, 32'h000F_0000, 1'b1, 16'h1005},
        '{32'h0000_0009, 32'h0000_0000, 32'h0000_0032, 32'h000E_0000, 1'b1, 16'h0000},
        '{32'h0000_0009, 32'h0000_0009, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1004},
        '{32'h0000_0009, 32'h0000_000A, 32'h0000_0031, 32'h0002_0000, 1'b1, 16'h1004},
        '{32'h0000_0009, 32'h0000_000A, 32'h0098_9681, 32'h0002_0000, 1'b1, 16'h1004},
        '{32'h0000_0009, 32'h0098_9681, 32'h0098_9680, 32'h0002_0000, 1'b1, 16'h1004},
        '{32'h0000_0009, 32'h0000_0033, 32'h0000_0032, 32'h0002_0000, 1'b1, 16'h1004},
        '{32'h0000_0009, 32'h0000_0032, 32'h0000_0032, 32'h0002_0000, 1'b0, 16'h0000},
        '{32'h0000_0009, 32'h0000_0009, 32'h0000_0032, 32'h0002_0000, 1'b0, 16'h1004},
        '{32'h0000_0009, 32'h0000_000A, 32'h0098_9680, 32'h0002_0000, 1'b1, 16'h0000}
    };

    ccpo_top #(.TICK_DIV(DIV), .CNT_W(24)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .match_out1(match_out1), .match_out2(match_out2),
        .operation_error_flag(operation_error_flag)
    );

    ccpo_load load (
        .pclk(pclk), .presetn(presetn), .pwm_in(match_out1),
        .high_len(high_len), .period(period), .rises(rises)
    );

    always #50 pclk = ~pclk;

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    always @(posedge pclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 6000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Called just after a rising edge; ready and read data are taken at the access edge,
    // then one idle edge passes so the next call never re-drives psel in the same step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        check({31'h0, pready}, 32'h0);
    endtask : apb

    task automatic pwm_run(input logic [31:0] on, input logic [31:0] cyc);
        apb(1'b1, ccpo_pkg::ON_WIDTH_OFS, on);
        apb(1'b1, ccpo_pkg::CYCLE_OFS, cyc);
        apb(1'b1, ccpo_pkg::EXEC_OFS, 32'h1);
    endtask : pwm_run

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({31'h0, match_out2}, 32'h1);
        check({31'h0, operation_error_flag}, 32'h0);
        @(posedge pclk);
        apb(1'b0, ccpo_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h4);
        apb(1'b0, 8'h24, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        check({31'h0, er}, 32'h1);
        apb(1'b0, ccpo_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, ccpo_pkg::AREA_END_OFS, 32'h0000_0010);
        foreach (rows[i])
        begin
            apb(1'b1, ccpo_pkg::CTRL_OFS, rows[i].ctrl);
            apb(1'b1, ccpo_pkg::ON_WIDTH_OFS, rows[i].on);
            apb(1'b1, ccpo_pkg::CYCLE_OFS, rows[i].cyc);
            apb(1'b1, ccpo_pkg::ARG_LOC_OFS, rows[i].loc);
            apb(1'b1, ccpo_pkg::ERR_FLAG_OFS, 32'h1);
            apb(1'b1, ccpo_pkg::EXEC_OFS, {31'h0, rows[i].cond});
            apb(1'b0, ccpo_pkg::ERR_CODE_OFS, 32'h0);
            check({31'h0, operation_error_flag}, {31'h0, rows[i].code != 16'h0});
            if (rows[i].code != 16'h0)
                check(rd, {16'h0, rows[i].code});
        end
        apb(1'b1, ccpo_pkg::ARG_LOC_OFS, 32'h0002_0000);
        // Stop the last row's run so the next start is a fresh one
        apb(1'b1, ccpo_pkg::EXEC_OFS, 32'h0);
        pwm_run(32'h0000_000A, 32'h0000_0032);
        repeat (5)
        begin
            @(negedge pclk);
            check({31'h0, match_out1}, 32'h0);
        end
        repeat (160) @(posedge pclk);
        check(high_len, 32'h0000_000A * DIV);
        check(period, 32'h0000_0032 * DIV);
        pwm_run(32'h0000_0019, 32'h0000_003C);
        repeat (200) @(posedge pclk);
        check(high_len, 32'h0000_0019 * DIV);
        check(period, 32'h0000_003C * DIV);
        pwm_run(32'h0000_0032, 32'h0000_0032);
        repeat (100) @(posedge pclk);
        n = 0;
        repeat (100)
        begin
            @(negedge pclk);
            n = n + {31'h0, match_out1};
        end
        check(n, 32'h0000_0064);
        apb(1'b1, ccpo_pkg::EXEC_OFS, 32'h0);
        @(negedge pclk);
        check({31'h0, match_out1}, 32'h0);
        @(posedge pclk);
        pwm_run(32'h0000_0000, 32'h0000_0032);
        n = rises;
        repeat (150) @(posedge pclk);
        check(rises, n);
        apb(1'b1, ccpo_pkg::CTRL_OFS, 32'h19);
        @(negedge pclk);
        check({31'h0, match_out2}, 32'h0);
        @(posedge pclk);
        apb(1'b1, ccpo_pkg::CTRL_OFS, 32'h39);
        @(negedge pclk);
        check({31'h0, match_out2}, 32'h1);
        @(posedge pclk);
        // Disabled counter raises the flag, then software clears it
        apb(1'b1, ccpo_pkg::CTRL_OFS, 32'h38);
        apb(1'b1, ccpo_pkg::EXEC_OFS, 32'h1);
        check({31'h0, operation_error_flag}, 32'h1);
        apb(1'b1, ccpo_pkg::ERR_FLAG_OFS, 32'h1);
        check({31'h0, operation_error_flag}, 32'h0);
        // Reset in mid-run while the output is high and the second output off
        apb(1'b1, ccpo_pkg::CTRL_OFS, 32'h19);
        pwm_run(32'h0000_0032, 32'h0000_0032);
        @(negedge pclk);
        check({30'h0, match_out2, match_out1}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check({30'h0, match_out2, match_out1}, 32'h2);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ccpo_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h4);
        apb(1'b0, ccpo_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        results();
    end
endmodule : counter_channel_pwm_output_tb
